// ---- cap_ca_parity_checker.sv ----
// Contract
// - latency code decode, zero disables checking
// - delay selected commands by parity latency
// - add latency to read and write latency
// - parity covers command, address, bank, chip id
// - unused address inputs count as zero
// - parity is even including parity bit
// - drop bad command and uncertain window
// - log failing frame until cleared
// - status set before alert release
// - alert low within assert delay
// - wait row time, precharge, block commands
// - release after min width and precharge
// - after max width run, unchecked until cleared
// - latency write only, status clears only
// - persistent mode keeps checking after max width run
// - bad self refresh entry gives power down
`timescale 1ns/1ps
module cap_ca_parity_checker (
  input  logic                sys_clk,             // command clock
  input  logic                rst_n,               // sync reset, active low
  input  logic                cs_n_pin,            // chip select pin, active low
  input  logic                cke_pin,             // clock enable pin
  input  cap_pkg::cap_frame_t ca_pin,              // command/address pins
  input  logic                parity_bit_in,       // parity pin
  input  logic                mr_wr,               // mode register write pulse
  input  logic [2:0]          mr_parity_latency,   // latency code written
  input  logic                mr_persist,          // persistent mode written
  input  logic                mr_status_clr,       // write of zero to status
  input  logic [4:0]          add_lat,             // additive latency
  input  logic [4:0]          cas_wr_lat,          // cas write latency
  input  logic [4:0]          cas_lat,             // cas latency
  output logic                alert_n,             // alert, active low
  output logic                parity_error_status, // sticky status bit
  output cap_pkg::cap_log_t   err_log,             // logged erroneous frame
  output logic                exec_valid,          // command executes now
  output cap_pkg::cap_frame_t exec_frame,          // frame being executed
  output logic                enter_pd,            // power down instead of sre
  output logic                precharge_all,       // close all banks pulse
  output logic [6:0]          write_latency,       // total write latency
  output logic [6:0]          read_latency         // total read latency
);
  localparam int ONE = 1;

  cap_pkg::cap_pins_t  pins_in;
  cap_pkg::cap_pins_t  pins_m_q;
  cap_pkg::cap_pins_t  pins_s_q;
  logic                cke_prev_q;
  logic [2:0]          lat_code_q;
  logic                persist_q;
  logic [3:0]          lat_clk;
  logic [3:0]          tap_full;
  logic                odd;
  logic                cmd;
  logic                check_en;
  logic                err;
  logic                accept;
  logic                is_sre;
  logic                line_valid;
  cap_pkg::cap_frame_t line_data;
  cap_pkg::cap_state_t st_q;
  cap_pkg::cap_state_t st_d;
  logic [7:0]          cnt_q;
  logic                closed_q;
  logic                alert_n_q;
  logic                status_q;
  cap_pkg::cap_log_t   log_q;
  logic                exec_valid_q;
  cap_pkg::cap_frame_t exec_frame_q;
  logic                enter_pd_q;
  logic                prech_q;
  logic [6:0]          wl_q;
  logic [6:0]          rl_q;

  // all pin inputs cross on two flops before any logic
  assign pins_in = '{frame: ca_pin, pbit: parity_bit_in, cs_n: cs_n_pin, cke: cke_pin};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pins_m_q <= '{default: '0, cs_n: 1'b1};
      pins_s_q <= '{default: '0, cs_n: 1'b1};
    end else begin
      pins_m_q <= pins_in;
      pins_s_q <= pins_m_q;
    end
  end

  // previous cke, to spot self refresh entry
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= pins_s_q.cke;
    end
  end

  // latency field; no readback port, it is write only
  // ignore direct latency change
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lat_code_q <= cap_pkg::LAT_OFF;
      persist_q  <= 1'b0;
    end else if (mr_wr) begin
      persist_q <= mr_persist;
      if (lat_code_q == cap_pkg::LAT_OFF || mr_parity_latency == cap_pkg::LAT_OFF) begin
        lat_code_q <= mr_parity_latency;
      end
    end
  end

  always_comb begin
    case (lat_code_q)
      cap_pkg::LAT_CODE4: lat_clk = cap_pkg::LAT_CLK4;
      cap_pkg::LAT_CODE5: lat_clk = cap_pkg::LAT_CLK5;
      cap_pkg::LAT_CODE6: lat_clk = cap_pkg::LAT_CLK6;
      cap_pkg::LAT_CODE8: lat_clk = cap_pkg::LAT_CLK8;
      default:            lat_clk = cap_pkg::LAT_CLK0;
    endcase
  end

  // unconnected pins tie low at pad
  cap_parity_tree u_tree (
    .frame (pins_s_q.frame),
    .pbit  (pins_s_q.pbit),
    .odd   (odd)
  );

  assign cmd      = !pins_s_q.cs_n;
  assign check_en = (lat_clk != cap_pkg::LAT_CLK0) && (st_q == cap_pkg::ST_IDLE)
                    && (!status_q || persist_q);
  assign err      = cmd && check_en && odd;
  assign accept   = cmd && (st_q == cap_pkg::ST_IDLE) && !err;
  assign is_sre   = ({pins_s_q.frame.act_n, pins_s_q.frame.a16_ras_n,
                      pins_s_q.frame.a15_cas_n, pins_s_q.frame.a14_we_n} == cap_pkg::CMD_REF)
                    && cke_prev_q && !pins_s_q.cke;

  // delay so the line alone gives exactly the latency, the exec flop is shared with the direct path
  assign tap_full = lat_clk - cap_pkg::TAP_BIAS;

  cap_delay_line u_line (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wr_valid (accept && (lat_clk != cap_pkg::LAT_CLK0)),
    .wr_data  (pins_s_q.frame),
    .tap      (tap_full[2:0]),
    .flush    (err),
    .rd_valid (line_valid),
    .rd_data  (line_data)
  );

  // execution stage; a dropped command never reaches exec_valid
  // erroneous command never executes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      exec_valid_q <= 1'b0;
      exec_frame_q <= '0;
    end else if (lat_clk == cap_pkg::LAT_CLK0) begin
      exec_valid_q <= accept;
      exec_frame_q <= pins_s_q.frame;
    end else begin
      exec_valid_q <= line_valid && !err;
      exec_frame_q <= line_data;
    end
  end

  // alert sequence state
  always_comb begin
    st_d = st_q;
    case (st_q)
      cap_pkg::ST_IDLE: begin
        if (err) begin
          st_d = cap_pkg::ST_HOLD;
        end
      end
      cap_pkg::ST_HOLD: begin
        if (cnt_q >= cap_pkg::PW_MIN_CYC && closed_q) begin
          st_d = cap_pkg::ST_TAIL;
        end
      end
      cap_pkg::ST_TAIL: begin
        if (cnt_q >= cap_pkg::PW_MAX_CYC) begin
          st_d = cap_pkg::ST_IDLE;
        end
      end
      default: st_d = cap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= cap_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // cycles since the error was seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_d == cap_pkg::ST_IDLE) begin
      cnt_q <= cap_pkg::CNT_ZERO;
    end else if (st_q == cap_pkg::ST_IDLE) begin
      cnt_q <= cap_pkg::CNT_ONE;
    end else begin
      cnt_q <= cnt_q + cap_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q == cap_pkg::ST_IDLE) begin
      prech_q  <= 1'b0;
      closed_q <= 1'b0;
    end else begin
      prech_q  <= (st_q == cap_pkg::ST_HOLD) && (cnt_q == cap_pkg::TRAS_CYC);
      closed_q <= closed_q || prech_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alert_n_q <= 1'b1;
    end else if (st_d == cap_pkg::ST_HOLD) begin
      alert_n_q <= 1'b0;
    end else begin
      alert_n_q <= 1'b1;
    end
  end

  // set wins over clear; a clear during the alert pulse is ignored
  // status set at error
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (err) begin
      status_q <= 1'b1;
    end else if (mr_status_clr && st_q != cap_pkg::ST_HOLD) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      log_q <= '0;
    end else if (err) begin
      log_q <= '{frame: pins_s_q.frame, pbit: pins_s_q.pbit};
    end else if (mr_status_clr && st_q != cap_pkg::ST_HOLD) begin
      log_q <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enter_pd_q <= 1'b0;
    end else begin
      enter_pd_q <= err && is_sre;
    end
  end

  // latency added to wl and rl
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wl_q <= '0;
      rl_q <= '0;
    end else begin
      wl_q <= {2'b00, add_lat} + {2'b00, cas_wr_lat} + {3'b000, lat_clk};
      rl_q <= {2'b00, add_lat} + {2'b00, cas_lat} + {3'b000, lat_clk};
    end
  end

  assign alert_n             = alert_n_q;
  assign parity_error_status = status_q;
  assign err_log             = log_q;
  assign exec_valid          = exec_valid_q;
  assign exec_frame          = exec_frame_q;
  assign enter_pd            = enter_pd_q;
  assign precharge_all       = prech_q;
  assign write_latency       = wl_q;
  assign read_latency        = rl_q;

  // alert sequence: timing of the low pulse against the counter
  a_alert_on_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err |=> !alert_n_q) else $error("alert not low after error");
  a_status_before_rel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(alert_n_q) |-> status_q) else $error("status clear at release");
  a_pulse_min_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(alert_n_q) |-> cnt_q > cap_pkg::PW_MIN_CYC) else $error("alert pulse short");
  a_release_closed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(alert_n_q) |-> closed_q) else $error("alert released with open banks");
  a_prech_row_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(prech_q) |-> $past(cnt_q) == cap_pkg::TRAS_CYC) else $error("precharge early");
  a_prech_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prech_q |=> !prech_q) else $error("precharge pulse too long");

  // command path: nothing runs from the error until the window ends
  a_drop_bad_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err |=> !exec_valid_q [*2]) else $error("command ran after error");
  a_block_in_alert: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q != cap_pkg::ST_IDLE |=> !exec_valid_q) else $error("command ran in alert");
  a_bypass_no_lat: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && lat_clk == cap_pkg::LAT_CLK0 ##ONE lat_clk == cap_pkg::LAT_CLK0
    |-> exec_valid_q) else $error("disabled latency not direct");
  // line of four plus the exec flop: five edges from the accept edge
  a_latency_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && lat_clk == cap_pkg::LAT_CLK4 && !err ##1 (!err && st_q == cap_pkg::ST_IDLE) [*5]
    |-> exec_valid_q) else $error("latency four not applied");
  a_unchecked_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_q && !persist_q && cmd && st_q == cap_pkg::ST_IDLE |-> accept)
    else $error("checked while status set");

  // error bookkeeping
  a_sre_power_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err && is_sre |=> enter_pd_q ##1 !enter_pd_q) else $error("sre error no power down");
  a_pd_needs_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enter_pd_q |-> $past(err) && $past(is_sre)) else $error("power down without error");
  a_status_on_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err |=> status_q) else $error("status not set by error");
  a_log_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err |=> log_q.frame == $past(pins_s_q.frame)) else $error("log missed frame");

  // latency field: a direct change would mistime commands already in the line
  a_direct_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mr_wr && lat_code_q != cap_pkg::LAT_OFF && mr_parity_latency != cap_pkg::LAT_OFF
    |=> $stable(lat_code_q)) else $error("direct latency change taken");

  // no disable here, this one watches the reset itself
  a_reset_quiet: assert property (@(posedge sys_clk)
    !rst_n |=> alert_n_q && !status_q && log_q == '0) else $error("reset state wrong");
endmodule : cap_ca_parity_checker

// ---- cap_pkg.sv ----
package cap_pkg;

  // command/address frame as sampled on the pins
  typedef struct packed {
    logic [2:0]  chip_id;
    logic        act_n;
    logic [1:0]  bank_group;
    logic [1:0]  bank;
    logic        a17;
    logic        a16_ras_n;
    logic        a15_cas_n;
    logic        a14_we_n;
    logic [13:0] addr;
  } cap_frame_t;

  // one erroneous frame together with its parity bit
  typedef struct packed {
    cap_frame_t frame;
    logic       pbit;
  } cap_log_t;

  // everything that crosses in from the pins
  typedef struct packed {
    cap_frame_t frame;
    logic       pbit;
    logic       cs_n;
    logic       cke;
  } cap_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_TAIL = 2'b10
  } cap_state_t;

  // parity latency codes
  localparam logic [2:0] LAT_OFF  = 3'h0;
  localparam logic [2:0] LAT_CODE4 = 3'h1;
  localparam logic [2:0] LAT_CODE5 = 3'h2;
  localparam logic [2:0] LAT_CODE6 = 3'h3;
  localparam logic [2:0] LAT_CODE8 = 3'h4;
  localparam logic [3:0] LAT_CLK0 = 4'h0;
  localparam logic [3:0] LAT_CLK4 = 4'h4;
  localparam logic [3:0] LAT_CLK5 = 4'h5;
  localparam logic [3:0] LAT_CLK6 = 4'h6;
  localparam logic [3:0] LAT_CLK8 = 4'h8;
  localparam logic [3:0] TAP_BIAS = 4'h2;

  localparam int DEPTH = 8;

  // timing, figures in ns, counts in cycles of sys_clk
  localparam int CLK_NS      = 100;
  localparam int ALERT_ON_NS = 1000;
  localparam int PW_MIN_NS   = 6000;
  localparam int PW_MAX_NS   = 10000;
  localparam int TRAS_NS     = 3500;
  localparam logic [7:0] ALERT_ON_CYC = 8'(ALERT_ON_NS / CLK_NS);
  localparam logic [7:0] PW_MIN_CYC   = 8'((PW_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PW_MAX_CYC   = 8'(PW_MAX_NS / CLK_NS);
  localparam logic [7:0] TRAS_CYC     = 8'((TRAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [7:0] CNT_ZERO     = 8'h00;

  // refresh encoding: act_n, ras_n, cas_n, we_n
  localparam logic [3:0] CMD_REF = 4'h9;

endpackage : cap_pkg

// ---- cap_parity_tree.sv ----
`timescale 1ns/1ps
module cap_parity_tree (
  input  cap_pkg::cap_frame_t frame, // covered inputs
  input  logic                pbit,  // parity bit from the pins
  output logic                odd    // high when the count of ones is odd
);
  localparam int W = $bits(cap_pkg::cap_frame_t);
  logic [W:0] chain;
  logic [W-1:0] bits;

  assign bits     = frame;
  assign chain[0] = pbit;
  // one xor stage per covered bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_xor
      assign chain[i+1] = chain[i] ^ bits[i];
    end
  endgenerate
  assign odd = chain[W];
endmodule : cap_parity_tree

// ---- cap_delay_line.sv ----
`timescale 1ns/1ps
module cap_delay_line (
  input  logic                sys_clk,  // command clock
  input  logic                rst_n,    // sync reset, active low
  input  logic                wr_valid, // command enters the line
  input  cap_pkg::cap_frame_t wr_data,  // command frame
  input  logic [2:0]          tap,      // stage picked for output
  input  logic                flush,    // drop all held commands
  output logic                rd_valid, // registered output valid
  output cap_pkg::cap_frame_t rd_data   // registered output frame
);
  logic                vld_q [cap_pkg::DEPTH];
  cap_pkg::cap_frame_t dat_q [cap_pkg::DEPTH];

  // one stage per clock of latency
  genvar i;
  generate
    for (i = 0; i < cap_pkg::DEPTH; i++) begin : g_stage
      // head and body split at elaboration, so no stage ever names index -1
      if (i == 0) begin : g_head
        always_ff @(posedge sys_clk) begin
          if (!rst_n || flush) begin
            vld_q[i] <= 1'b0;
          end else begin
            vld_q[i] <= wr_valid;
          end
        end
        always_ff @(posedge sys_clk) begin
          dat_q[i] <= wr_data;
        end
      end else begin : g_body
        always_ff @(posedge sys_clk) begin
          if (!rst_n || flush) begin
            vld_q[i] <= 1'b0;
          end else begin
            vld_q[i] <= vld_q[i-1];
          end
        end
        always_ff @(posedge sys_clk) begin
          dat_q[i] <= dat_q[i-1];
        end
      end
    end
  endgenerate

  // read register, cleared with the line
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= vld_q[tap];
      rd_data  <= dat_q[tap];
    end
  end
endmodule : cap_delay_line

// ---- cap_ctrl_model.sv ----
`timescale 1ns/1ps
module cap_ctrl_model (
  input  logic                sys_clk,       // command clock
  input  logic                alert_n,       // alert from device, active low
  output logic                cs_n_pin,      // chip select, active low
  output logic                cke_pin,       // clock enable
  output cap_pkg::cap_frame_t ca_pin,        // command/address lines
  output logic                parity_bit_in  // parity line
);
  // idle bus at start: deselected, unused lines low
  initial begin
    cs_n_pin      = 1'b1;
    cke_pin       = 1'b1;
    ca_pin        = '0;
    parity_bit_in = 1'b0;
  end

  // one selected command cycle, then deselect
  task automatic issue(input cap_pkg::cap_frame_t f, input logic cke, input logic flip);
    // no command while alert is low
    while (alert_n !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    cs_n_pin <= 1'b0;
    cke_pin  <= cke;
    // unused lines are driven low by caller
    ca_pin   <= f;
    // even parity, flip only when told
    parity_bit_in <= (^f) ^ flip;
    @(posedge sys_clk);
    // deselect between commands, lines toggled so stale values never match
    cs_n_pin      <= 1'b1;
    cke_pin       <= 1'b1;
    ca_pin        <= ~f;
    parity_bit_in <= ~((^f) ^ flip);
  endtask : issue
endmodule : cap_ctrl_model

// ---- cap_ca_parity_checker_tb.sv ----
`timescale 1ns/1ps
module cap_ca_parity_checker_tb;
  logic                sys_clk, rst_n, cs_n_pin, cke_pin, parity_bit_in;
  logic                mr_wr, mr_persist, mr_status_clr;
  logic [2:0]          mr_parity_latency;
  logic [4:0]          add_lat, cas_wr_lat, cas_lat;
  cap_pkg::cap_frame_t ca_pin, exec_frame, fr;
  cap_pkg::cap_log_t   err_log;
  logic                alert_n, parity_error_status, exec_valid, enter_pd, precharge_all;
  logic [6:0]          write_latency, read_latency;
  logic [25:0]         w;
  logic                st_rel;
  int                  bad_count, comparisons, cycles, got;
  int                  t_low, t_high, t_pre, n_exec, n_pre, n_pd;
  int                  lat_tab [8] = '{0, 4, 5, 6, 8, 0, 0, 0};

  // 10 MHz command clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  cap_ca_parity_checker uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .cke_pin(cke_pin),
    .ca_pin(ca_pin), .parity_bit_in(parity_bit_in), .mr_wr(mr_wr),
    .mr_parity_latency(mr_parity_latency), .mr_persist(mr_persist),
    .mr_status_clr(mr_status_clr), .add_lat(add_lat), .cas_wr_lat(cas_wr_lat),
    .cas_lat(cas_lat), .alert_n(alert_n), .parity_error_status(parity_error_status),
    .err_log(err_log), .exec_valid(exec_valid), .exec_frame(exec_frame),
    .enter_pd(enter_pd), .precharge_all(precharge_all),
    .write_latency(write_latency), .read_latency(read_latency));

  cap_ctrl_model u_ctrl (
    .sys_clk(sys_clk), .alert_n(alert_n), .cs_n_pin(cs_n_pin), .cke_pin(cke_pin),
    .ca_pin(ca_pin), .parity_bit_in(parity_bit_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // mode write; settles a few cycles before anyone looks
  task automatic mode(input logic [2:0] code, input logic persist);
    @(posedge sys_clk);
    mr_wr             <= 1'b1;
    mr_parity_latency <= code;
    mr_persist        <= persist;
    @(posedge sys_clk);
    mr_wr <= 1'b0;
    // mode delay stretched by the longest latency
    repeat (12) @(posedge sys_clk);
  endtask : mode

  // one command, counted in edges from the one that drives it onto the pins
  task automatic measure(input cap_pkg::cap_frame_t f, input logic flip, input int exp);
    u_ctrl.issue(f, 1'b1, flip);
    got = 0;
    // issue returns on the edge after launch, so the next edge is the second
    for (int i = 2; i <= 21 && got == 0; i++) begin
      @(posedge sys_clk);
      #1;
      if (exec_valid === 1'b1) begin
        got = i;
        check(exec_frame, f, "executed frame");
      end
    end
    check(got, exp, "execution delay");
  endtask : measure

  // watch the alert sequence; a clear is tried while alert is low
  task automatic watch(input int n, input int clr_at);
    t_low  = 0;
    t_high = 0;
    t_pre  = 0;
    n_exec = 0;
    n_pre  = 0;
    n_pd   = 0;
    // edges counted from the one that put the bad frame out
    for (int i = 2; i <= n; i++) begin
      @(posedge sys_clk);
      mr_status_clr <= (i == clr_at);
      #1;
      if (exec_valid === 1'b1) n_exec++;
      if (enter_pd === 1'b1) n_pd++;
      if (precharge_all === 1'b1) begin
        n_pre++;
        t_pre = i;
      end
      if (alert_n === 1'b0 && t_low == 0) t_low = i;
      if (alert_n === 1'b1 && t_low != 0 && t_high == 0) begin
        t_high = i;
        st_rel = parity_error_status;
      end
    end
  endtask : watch

  // good command then a bad one right behind it, so the good one sits in the line
  task automatic err_seq(input cap_pkg::cap_frame_t f, input logic cke, input int pd);
    // the good command must be flushed, commands executed counts it
    u_ctrl.issue(f ^ 26'h000_0003, 1'b1, 1'b0);
    u_ctrl.issue(f, cke, 1'b1);
    watch(110, 20);
    check(t_low, 3, "alert low delay");
    check(32'(t_high - t_low >= 32'(cap_pkg::PW_MIN_CYC)), 1, "alert too short");
    check(32'(t_pre - t_low >= 32'(cap_pkg::TRAS_CYC)), 1, "precharge before row time");
    check(32'(t_high - t_low <= 32'(cap_pkg::PW_MAX_CYC)), 1, "alert too long");
    check(32'(t_pre < t_high && t_pre > 0), 1, "precharge before release");
    check(n_pre, 1, "precharge pulses");
    check(st_rel, 1'b1, "status at release");
    check(n_exec, 0, "commands executed");
    check(n_pd, pd, "power down pulses");
    check(parity_error_status, 1'b1, "status after clear in alert");
    check(err_log, 32'({f, ~(^f)}), "error log");
  endtask : err_seq

  // cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      $display("BAD at %0t: timeout", $time);
      results();
    end
  end

  initial begin
    rst_n             = 1'b0;
    mr_wr             = 1'b0;
    mr_parity_latency = 3'h0;
    mr_persist        = 1'b0;
    mr_status_clr     = 1'b0;
    add_lat           = 5'h03;
    cas_wr_lat        = 5'h09;
    cas_lat           = 5'h0b;
    bad_count         = 0;
    comparisons       = 0;
    cycles            = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check(alert_n, 1'b1, "reset alert");
    check(parity_error_status, 1'b0, "reset status");
    check(err_log, 32'h0000_0000, "reset log");
    // every code; off and reserved codes run bad parity unchecked
    for (int c = 0; c < 8; c++) begin
      mode(3'h0, 1'b0);
      mode(3'(c), 1'b0);
      check(write_latency, 12 + lat_tab[c], "write latency");
      check(read_latency, 14 + lat_tab[c], "read latency");
      fr = cap_pkg::cap_frame_t'(26'h155_5555 ^ 26'(c));
      measure(fr, lat_tab[c] == 0, 3 + lat_tab[c]);
    end
    // walking one: every covered line counts in the parity
    mode(3'h0, 1'b0);
    mode(3'h1, 1'b0);
    // a direct change to six clocks must be refused, four stays in force
    mode(3'h3, 1'b0);
    check(write_latency, 16, "direct latency change taken");
    for (int j = 0; j < 26; j++) begin
      w = 26'h000_0001 << j;
      measure(cap_pkg::cap_frame_t'(w), 1'b0, 7);
    end
    // failing self refresh entry
    fr = '0;
    {fr.act_n, fr.a16_ras_n, fr.a15_cas_n, fr.a14_we_n} = cap_pkg::CMD_REF;
    fr.bank = 2'h2;
    err_seq(fr, 1'b0, 1);
    // extra refresh after the error, runs unchecked
    measure(fr ^ 26'h000_0010, 1'b1, 7);
    check(alert_n, 1'b1, "unchecked after window");
    @(posedge sys_clk);
    mr_status_clr <= 1'b1;
    @(posedge sys_clk);
    mr_status_clr <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(parity_error_status, 1'b0, "status cleared");
    check(err_log, 32'h0000_0000, "log cleared");
    // persistent: second error caught while status still set
    mode(3'h1, 1'b1);
    err_seq(cap_pkg::cap_frame_t'(26'h0a_aaaa), 1'b1, 0);
    err_seq(cap_pkg::cap_frame_t'(26'h13_0f00), 1'b1, 0);
    results();
  end
endmodule : cap_ca_parity_checker_tb
